// >>> logic/rx_power_defines.vh
// Constants for the wireless receiver power control block
// Summary of operation
// RULE_01: Host keeps done high, fault low normally
// RULE_02: Fault drive pulls pin low, shut down
// RULE_03: Pin pulled to battery means charge complete
// RULE_04: Overtemperature stops regulator, sends internal fault
// RULE_05: Report received power including all losses
// RULE_06: Identify at start-up via modulation switches
// RULE_07: Send rectifier error packets until settled
// RULE_08: Step rectifier target among four thresholds
// RULE_09: Hold regulator off until first target converges
// RULE_10: Steady error packet every 250 ms
// RULE_11: Large overshoot shortens period to 32 ms
// RULE_12: Keep output regulated while delivering power
// RULE_13: End transfer on removal, loss, request
// RULE_14: Bias window 24 ms, deglitched comparators
// RULE_15: Released bias, pin above 100 mV is control
// RULE_16: Host never drives done low with fault high
`ifndef RX_POWER_DEFINES_VH
`define RX_POWER_DEFINES_VH
`define CLK_HZ              20000000
`define BIAS_WINDOW_MS      24
`define DEGLITCH_MS         10
`define STD_PERIOD_MS       250
`define FAST_PERIOD_MS      32
`define MS_CYCLES           (`CLK_HZ / 1000)
`define EPT_CHARGE_COMPLETE 8'h01
`define EPT_INTERNAL_FAULT  8'h02
`define EPT_NO_RESPONSE     8'h00
`define HDR_ERROR           8'h03
`define HDR_RX_POWER        8'h04
`define HDR_EPT             8'h02
`define HDR_IDENT           8'h71
`define TARGET_COUNT        4
`endif

// >>> logic/ms_tick.v
// Millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
`include "rx_power_defines.vh"
module ms_tick
#(
    parameter integer CYCLES = `MS_CYCLES
)
(
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Enable output
    output reg  tick
);
    reg [15:0] count;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end
        else if (count == CYCLES[15:0] - 16'h0001)
        begin
            count <= 16'h0000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // ms_tick
`default_nettype wire

// >>> logic/wireless_rx_power_control.v
// Receiver power control: pin decode, protection, packet pacing
`timescale 1ns/1ps
`default_nettype none
`include "rx_power_defines.vh"
module wireless_rx_power_control
#(
    parameter integer MS_CYCLES  = `MS_CYCLES,
    parameter integer WIN_MS     = `BIAS_WINDOW_MS,
    parameter integer DGL_MS     = `DEGLITCH_MS,
    parameter integer STD_MS     = `STD_PERIOD_MS,
    parameter integer FAST_MS    = `FAST_PERIOD_MS
)
(
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Analog comparator and status inputs (asynchronous)
    input  wire       hot_cmp,
    input  wire       cold_cmp,
    input  wire       ctrl_above_thr,
    input  wire       pin_at_battery,
    input  wire       die_overtemp,
    input  wire       rectifier_node_present,
    input  wire       rectifier_node_above,
    input  wire       rectifier_node_below,
    input  wire       rectifier_node_overshoot,
    input  wire       load_step_up,
    input  wire       load_step_down,
    input  wire       rx_stop_req,
    // Packet engine handshake
    input  wire       pkt_busy,
    output reg        pkt_send,
    output reg  [7:0] pkt_header,
    output reg  [7:0] pkt_payload,
    output reg        modulation_switch,
    // Regulator and sensor controls
    output reg        sensor_bias_window,
    output reg        regulator_enable,
    output reg  [1:0] rectifier_target_voltage,
    output reg  [1:0] rectifier_node_error,
    // Status
    output reg        fault_flag,
    output reg        charge_done_flag,
    output reg        transfer_active
);
    localparam [2:0] ST_OFF   = 3'd0;
    localparam [2:0] ST_IDENT = 3'd1;
    localparam [2:0] ST_CONV  = 3'd2;
    localparam [2:0] ST_RUN   = 3'd3;
    localparam [2:0] ST_EPT   = 3'd4;
    localparam [2:0] ST_STOP  = 3'd5;

    // Two-stage synchronisers for all analog inputs
    localparam integer NS = 12;
    wire [NS-1:0] raw = {hot_cmp, cold_cmp, ctrl_above_thr, pin_at_battery, die_overtemp,
                         rectifier_node_present, rectifier_node_above, rectifier_node_below, rectifier_node_overshoot,
                         load_step_up, load_step_down, rx_stop_req};
    reg  [NS-1:0] sync1;
    reg  [NS-1:0] sync2;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= {NS{1'b0}};
            sync2 <= {NS{1'b0}};
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    wire s_hot   = sync2[11];
    wire s_cold  = sync2[10];
    wire s_ctrl  = sync2[9];
    wire s_batt  = sync2[8];
    wire s_otp   = sync2[7];
    wire s_rectifier_node  = sync2[6];
    wire s_above = sync2[5];
    wire s_below = sync2[4];
    wire s_over  = sync2[3];
    wire s_up    = sync2[2];
    wire s_down  = sync2[1];
    wire s_stop  = sync2[0];

    wire ms;
    ms_tick #(.CYCLES(MS_CYCLES)) u_tick
    (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (ms)
    );

    function [7:0] inc_sat;
        input [7:0] v;
        begin
            inc_sat = (v == 8'hff) ? v : v + 8'h01;
        end
    endfunction

    reg  [2:0] state;
    reg  [7:0] period_ms;
    reg  [7:0] hot_ms;
    reg  [7:0] cold_ms;
    reg        fast_mode;
    reg  [2:0] ident_step;
    // End-transfer code kept aside so the payload only moves with the send pulse
    reg  [7:0] ept_code;
    wire       settled = !s_above && !s_below;
    wire       sensor_trip = (hot_ms >= DGL_MS[7:0]) || (cold_ms >= DGL_MS[7:0]);
    wire [7:0] period_len = fast_mode ? FAST_MS[7:0] : STD_MS[7:0];
    wire       period_end = ms && (period_ms >= period_len - 8'h01);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state                    <= ST_OFF;
            period_ms                <= 8'h00;
            hot_ms                   <= 8'h00;
            cold_ms                  <= 8'h00;
            fast_mode                <= 1'b0;
            ident_step               <= 3'd0;
            ept_code                 <= 8'h00;
            pkt_send                 <= 1'b0;
            pkt_header               <= 8'h00;
            pkt_payload              <= 8'h00;
            modulation_switch        <= 1'b0;
            sensor_bias_window       <= 1'b0;
            regulator_enable         <= 1'b0;
            rectifier_target_voltage <= 2'd0;
            rectifier_node_error     <= 2'd0;
            fault_flag               <= 1'b0;
            charge_done_flag         <= 1'b0;
            transfer_active          <= 1'b0;
        end
        else
        begin
            pkt_send             <= 1'b0;
            rectifier_node_error <= {s_above, s_below};
            // Bias window then released monitoring within each packet period
            if (ms && state != ST_OFF)
            begin
                period_ms          <= period_end ? 8'h00 : period_ms + 8'h01;
                sensor_bias_window <= period_end || (period_ms < WIN_MS[7:0] - 8'h01); // [RULE_14]
                hot_ms  <= (sensor_bias_window && s_hot) ? inc_sat(hot_ms) : 8'h00;   // [RULE_14]
                cold_ms <= (sensor_bias_window && s_cold) ? inc_sat(cold_ms) : 8'h00; // [RULE_14]
            end
            case (state)
                ST_OFF:
                begin
                    regulator_enable <= 1'b0;
                    transfer_active  <= 1'b0;
                    period_ms        <= 8'h00;
                    if (s_rectifier_node)
                    begin
                        state      <= ST_IDENT;
                        ident_step <= 3'd0;
                        fast_mode  <= 1'b0;
                    end
                end
                ST_IDENT:
                begin
                    if (!pkt_busy && !pkt_send)
                    begin
                        ident_step        <= ident_step + 3'd1;
                        modulation_switch <= ~modulation_switch; // [RULE_06]
                        pkt_send          <= 1'b1;
                        pkt_header        <= `HDR_IDENT;
                        pkt_payload       <= {5'h00, ident_step};
                        if (ident_step == 3'd3)
                        begin
                            state                    <= ST_CONV;
                            rectifier_target_voltage <= 2'd0;
                            modulation_switch        <= 1'b0;
                        end
                    end
                end
                ST_CONV:
                begin
                    regulator_enable <= 1'b0; // [RULE_09]
                    if (settled)
                    begin
                        state            <= ST_RUN;
                        regulator_enable <= 1'b1; // [RULE_09] [RULE_12]
                        transfer_active  <= 1'b1;
                    end
                    else if (period_end && !pkt_busy)
                    begin
                        pkt_send    <= 1'b1; // [RULE_07]
                        pkt_header  <= `HDR_ERROR;
                        pkt_payload <= {6'h00, s_above, s_below};
                    end
                end
                ST_RUN:
                begin
                    if (s_over)
                        fast_mode <= 1'b1; // [RULE_11]
                    else if (settled && period_end)
                        fast_mode <= 1'b0;
                    if (s_up && rectifier_target_voltage != 2'd3)
                        rectifier_target_voltage <= rectifier_target_voltage + 2'd1; // [RULE_08]
                    else if (s_down && rectifier_target_voltage != 2'd0)
                        rectifier_target_voltage <= rectifier_target_voltage - 2'd1; // [RULE_08]
                    if (period_end && !pkt_busy)
                    begin
                        pkt_send    <= 1'b1; // [RULE_10] [RULE_07]
                        pkt_header  <= `HDR_ERROR;
                        pkt_payload <= {6'h00, s_above, s_below};
                    end
                    else if (ms && period_ms == 8'h0f && !pkt_busy)
                    begin
                        pkt_send    <= 1'b1; // [RULE_05]
                        pkt_header  <= `HDR_RX_POWER;
                        pkt_payload <= {6'h00, rectifier_target_voltage};
                    end
                end
                ST_EPT:
                begin
                    regulator_enable <= 1'b0;
                    transfer_active  <= 1'b0;
                    if (!pkt_busy && !pkt_send)
                    begin
                        pkt_send    <= 1'b1; // [RULE_13]
                        pkt_header  <= `HDR_EPT;
                        pkt_payload <= ept_code;
                        state      <= ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    regulator_enable <= 1'b0;
                    if (!s_rectifier_node)
                    begin
                        state            <= ST_OFF;
                        fault_flag       <= 1'b0;
                        charge_done_flag <= 1'b0;
                    end
                end
                default:
                    state <= ST_OFF;
            endcase
            // Shutdown causes override the sequence
            if (state != ST_OFF && state != ST_STOP && state != ST_EPT)
            begin
                if (!s_rectifier_node)
                begin
                    state            <= ST_OFF; // [RULE_13]
                    regulator_enable <= 1'b0;
                    transfer_active  <= 1'b0;
                end
                else if (s_otp)
                begin
                    state            <= ST_EPT;
                    regulator_enable <= 1'b0; // [RULE_04]
                    ept_code         <= `EPT_INTERNAL_FAULT;
                    fault_flag       <= 1'b1;
                end
                else if (!sensor_bias_window && s_batt)
                begin
                    state            <= ST_EPT;
                    regulator_enable <= 1'b0; // [RULE_03]
                    ept_code         <= `EPT_CHARGE_COMPLETE;
                    charge_done_flag <= 1'b1;
                end
                else if (!sensor_bias_window && !s_ctrl && period_ms > WIN_MS[7:0])
                begin
                    state            <= ST_EPT;
                    regulator_enable <= 1'b0; // [RULE_02] [RULE_15]
                    ept_code         <= `EPT_INTERNAL_FAULT;
                    fault_flag       <= 1'b1;
                end
                else if (sensor_trip || s_stop)
                begin
                    state            <= ST_EPT; // [RULE_13] [RULE_14]
                    regulator_enable <= 1'b0;
                    ept_code         <= `EPT_INTERNAL_FAULT;
                    fault_flag       <= 1'b1;
                end
            end
        end
    end
endmodule // wireless_rx_power_control
`default_nettype wire

// >>> testbench/rx_power_chk.sv
// Port checker for the receiver power control block
`timescale 1ns/1ps
`default_nettype none
module rx_power_chk
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Observed ports
    input wire logic       die_overtemp,
    input wire logic       pkt_busy,
    input wire logic       pkt_send,
    input wire logic [7:0] pkt_header,
    input wire logic [7:0] pkt_payload,
    input wire logic       modulation_switch,
    input wire logic       sensor_bias_window,
    input wire logic       regulator_enable,
    input wire logic [1:0] rectifier_target_voltage,
    input wire logic       fault_flag,
    input wire logic       transfer_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_busy_hold; pkt_send |-> !$past(pkt_busy); endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("packet sent while busy");
    property p_send_pulse; pkt_send |=> !pkt_send; endproperty
    a_send_pulse: assert property (p_send_pulse) else $error("send longer than a cycle");
    property p_hdr_hold; !pkt_send |-> $stable(pkt_header) && $stable(pkt_payload); endproperty
    a_hdr_hold: assert property (p_hdr_hold) else $error("packet bytes moved");
    property p_ot_off; die_overtemp [*8] |-> ##[0:40] !regulator_enable; endproperty
    a_ot_off: assert property (p_ot_off) else $error("regulator on when hot");
    property p_ot_ept;
        $fell(regulator_enable) && die_overtemp |-> ##[0:300] (pkt_send && pkt_header == 8'h02 && pkt_payload == 8'h02);
    endproperty
    a_ot_ept: assert property (p_ot_ept) else $error("no internal fault packet");
    property p_reg_start; $rose(regulator_enable) |-> (rectifier_target_voltage == 2'h0) ##[0:1] transfer_active; endproperty
    a_reg_start: assert property (p_reg_start) else $error("regulator start wrong");
    property p_ident_tog; pkt_send && pkt_header == 8'h71 |-> ##[0:1] $changed(modulation_switch); endproperty
    a_ident_tog: assert property (p_ident_tog) else $error("switch did not toggle");
    property p_bias_win; $rose(sensor_bias_window) |-> sensor_bias_window [*8]; endproperty
    a_bias_win: assert property (p_bias_win) else $error("bias window too short");
    c_ident: cover property (pkt_send && pkt_header == 8'h71);
    c_ept: cover property (pkt_send && pkt_header == 8'h02);
    c_fault: cover property ($rose(fault_flag));
endmodule // rx_power_chk
bind wireless_rx_power_control rx_power_chk u_chk (.clk, .rst_n, .die_overtemp, .pkt_busy, .pkt_send, .pkt_header,
    .pkt_payload, .modulation_switch, .sensor_bias_window, .regulator_enable, .rectifier_target_voltage,
    .fault_flag, .transfer_active);
`default_nettype wire

// >>> testbench/tx_ctrl_model.sv
// Transmitter controller model that takes receiver packets
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Packet link
    input  wire logic       slow,
    input  wire logic       pkt_send,
    input  wire logic [7:0] pkt_header,
    input  wire logic [7:0] pkt_payload,
    output var  logic       pkt_busy,
    output var  logic [7:0] last_header,
    output var  logic [7:0] last_payload
);
    logic [3:0] busy_cnt;
    // Busy while the packet goes over the coil
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_cnt <= 4'h0;
            last_header <= 8'h00;
            last_payload <= 8'h00;
        end
        else if (pkt_send)
        begin
            busy_cnt <= slow ? 4'hc : 4'h2;
            last_header <= pkt_header;
            last_payload <= pkt_payload;
        end
        else if (busy_cnt != 4'h0)
            busy_cnt <= busy_cnt - 4'h1;
    end
    assign pkt_busy = (busy_cnt != 4'h0);
endmodule // tx_ctrl_model
`default_nettype wire

// >>> testbench/wireless_rx_power_control_tb_top.sv
// Self-checking bench for the receiver power control block
`timescale 1ns/1ps
`default_nettype none
module wireless_rx_power_control_tb_top;
    localparam int MS = 20;
    logic       clk = 1'b0, rst_n = 1'b0, slow = 1'b0, hot_cmp = 1'b0, cold_cmp = 1'b0, ctrl_above_thr = 1'b1;
    logic       pin_at_battery = 1'b0, die_overtemp = 1'b0, rectifier_node_present = 1'b0, rectifier_node_above = 1'b0;
    logic       rectifier_node_below = 1'b0, rectifier_node_overshoot = 1'b0, load_step_up = 1'b0, load_step_down = 1'b0;
    logic       rx_stop_req = 1'b0;
    logic [1:0] tgt;
    wire        pkt_busy, pkt_send, modulation_switch, sensor_bias_window, regulator_enable;
    wire        fault_flag, charge_done_flag, transfer_active;
    wire  [7:0] pkt_header, pkt_payload, last_header, last_payload;
    wire  [1:0] rectifier_target_voltage, rectifier_node_error;
    int         err_total = 0, comparisons = 0, cyc_n = 0, t_err = 0, gap = 0, n_ident = 0, n_pwr = 0, k;

    always #25 clk = ~clk;

    wireless_rx_power_control #(.MS_CYCLES(MS)) DUT (.clk, .rst_n, .hot_cmp, .cold_cmp, .ctrl_above_thr,
        .pin_at_battery, .die_overtemp, .rectifier_node_present, .rectifier_node_above, .rectifier_node_below, .rectifier_node_overshoot,
        .load_step_up, .load_step_down, .rx_stop_req, .pkt_busy, .pkt_send, .pkt_header, .pkt_payload,
        .modulation_switch, .sensor_bias_window, .regulator_enable, .rectifier_target_voltage,
        .rectifier_node_error, .fault_flag, .charge_done_flag, .transfer_active);
    tx_ctrl_model u_tx (.clk, .rst_n, .slow, .pkt_send, .pkt_header, .pkt_payload, .pkt_busy,
        .last_header, .last_payload);

    // Packet log and error packet spacing
    always @(posedge clk)
    begin
        cyc_n++;
        if (pkt_send === 1'b1 && pkt_header === 8'h71)
            n_ident++;
        if (pkt_send === 1'b1 && pkt_header === 8'h04)
            n_pwr++;
        if (pkt_send === 1'b1 && pkt_header === 8'h03)
        begin
            gap = cyc_n - t_err;
            t_err = cyc_n;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic tally(input logic ok);
        comparisons++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("Error at %0t ns: value differs from expected", $time);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        tally(got === exp);
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        tally(got === exp);
    endtask
    task automatic check_cnt(input int got, input int exp);
        tally(got >= exp - MS && got <= exp + MS);
    endtask
    task automatic wait_bias(input logic lvl);
        for (k = 0; k < 6000 && sensor_bias_window !== lvl; k++)
            cyc(1);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic power_up();
        rectifier_node_present <= 1'b0;
        cyc(100);
        check_val({14'h0, fault_flag, charge_done_flag}, 16'h0);
        n_ident = 0;
        slow <= 1'($urandom % 2);
        ctrl_above_thr <= 1'b1;
        rectifier_node_present <= 1'b1;
        rectifier_node_above <= 1'b1;
        cyc(5500 + $urandom % 256);
        check_val({14'h0, rectifier_node_error}, 16'h2);
        check_bit(regulator_enable, 1'b0);
        rectifier_node_above <= 1'b0;
        for (k = 0; k < 12000 && regulator_enable !== 1'b1; k++)
            cyc(1);
        cyc(2);
        check_val(16'(n_ident), 16'h4);
        check_bit(transfer_active, 1'b1);
        $display("Test power up finished");
    endtask

    initial
    begin
        k = $urandom(65025);
        cyc(20);
        rst_n <= 1'b1;
        power_up();
        cyc(11000);
        check_cnt(gap, 250 * MS);
        check_bit(n_pwr > 0, 1'b1);
        rectifier_node_overshoot <= 1'b1;
        cyc(2000);
        check_cnt(gap, 32 * MS);
        rectifier_node_overshoot <= 1'b0;
        wait_bias(1'b0);
        wait_bias(1'b1);
        wait_bias(1'b0);
        check_cnt(k, 24 * MS);
        wait_bias(1'b1);
        // Comparator glitches shorter than the deglitch span
        repeat (2)
        begin
            {hot_cmp, cold_cmp} <= 2'(1 + $urandom % 2);
            cyc(1 + $urandom % 150);
            {hot_cmp, cold_cmp} <= 2'h0;
            cyc(20);
        end
        check_bit(transfer_active, 1'b1);
        load_step_up <= 1'b1;
        cyc(300);
        load_step_up <= 1'b0;
        tgt = rectifier_target_voltage;
        check_bit(tgt !== 2'h0, 1'b1);
        load_step_down <= 1'b1;
        cyc(300);
        load_step_down <= 1'b0;
        check_bit(rectifier_target_voltage !== tgt, 1'b1);
        die_overtemp <= 1'b1;
        cyc(400);
        check_bit(regulator_enable, 1'b0);
        check_val({last_header, last_payload}, 16'h0202);
        die_overtemp <= 1'b0;
        $display("Test steady run finished");
        // Charge complete, fault, local stop, held hot sensor; done flag set only on charge complete, fault flag in the other three
        for (int c = 0; c < 4; c++)
        begin
            power_up();
            pin_at_battery <= (c == 0);
            ctrl_above_thr <= (c != 1);
            rx_stop_req <= (c == 2);
            hot_cmp <= (c == 3);
            cyc(5500);
            check_bit(transfer_active, 1'b0);
            check_bit(regulator_enable, 1'b0);
            check_bit(charge_done_flag, c == 0);
            check_bit(fault_flag, c != 0);
            if (c == 0)
                check_val({last_header, last_payload}, 16'h0201);
            else
                check_val({last_header, last_payload}, 16'h0202);
            pin_at_battery <= 1'b0;
            ctrl_above_thr <= 1'b1;
            rx_stop_req <= 1'b0;
            hot_cmp <= 1'b0;
            $display("Test host stop %0d finished", c);
        end
        stop_test();
    end

    initial
    begin
        cyc(95000);
        err_total++;
        $display("Error at %0t ns: watchdog expired", $time);
        stop_test();
    end
endmodule // wireless_rx_power_control_tb_top
`default_nettype wire
